// ---- fpm_pkg.sv ----
// fpm_pkg: constants and carrier types for the flash protection mode control block
// assumes: one clock domain, synchronous active-high reset
package fpm_pkg;

  // ********************************************************************
  // protection modes
  // ********************************************************************
  typedef enum logic [2:0] {
    FPM_MODE_OPEN      = 3'b001,
    FPM_MODE_PROTECTED = 3'b010,
    FPM_MODE_LOCKED    = 3'b100
  } fpm_mode_type;

  // nonvolatile code of each mode, two bits
  localparam logic [1:0] FPM_NV_OPEN      = 2'h0;
  localparam logic [1:0] FPM_NV_PROTECTED = 2'h1;
  localparam logic [1:0] FPM_NV_LOCKED    = 2'h2;

  // mode-change request codes
  localparam logic [1:0] FPM_REQ_TO_OPEN      = 2'h0;
  localparam logic [1:0] FPM_REQ_TO_PROTECTED = 2'h1;
  localparam logic [1:0] FPM_REQ_TO_LOCKED    = 2'h2;

  // ********************************************************************
  // sizes, reset values and timing
  // ********************************************************************
  localparam int unsigned FPM_ROWS_DEF     = 256;
  localparam int unsigned FPM_ROW_AW_DEF   = 8;
  localparam logic        FPM_RST_BOOTED   = 1'b0;
  localparam logic [1:0]  FPM_RST_NV       = 2'h0;
  localparam int unsigned FPM_LOAD_CYCLES  = 2;

  // ********************************************************************
  // carriers
  // ********************************************************************
  // one flash access request: kind flags, row index, origin
  typedef struct packed {
    logic       valid;
    logic       rd;
    logic       wr;
    logic       er;
    logic [7:0] row;
    logic       internal;   // issued by supervisory system-call code
  } fpm_acc_type;

  // answer to an access request
  typedef struct packed {
    logic grant;
    logic deny;
  } fpm_ans_type;

endpackage

// ---- fpm_row_guard.sv ----
// fpm_row_guard: per-row write and read protection bitmaps
// assumes: bitmaps loaded by the parent from nonvolatile storage via set strobes
`timescale 1ns/10ps
module fpm_row_guard #(
  parameter int unsigned ROWS = fpm_pkg::FPM_ROWS_DEF,
  parameter int unsigned AW   = fpm_pkg::FPM_ROW_AW_DEF
) (
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          set_valid,
  input  wire logic [AW-1:0] set_row,
  input  wire logic          set_wprot,
  input  wire logic          set_rprot,
  input  wire logic          clear_all,
  input  wire logic [AW-1:0] chk_row,
  output logic               row_wprot,
  output logic               row_rprot
);

  logic [ROWS-1:0] wmap_q;
  logic [ROWS-1:0] rmap_q;

  // ********************************************************************
  // one flop pair per row
  // ********************************************************************
  // full erase wipes the markings together with the data
  genvar gi;
  generate
    for (gi = 0; gi < ROWS; gi++)
    begin : g_row
      always_ff @(posedge clock)
      begin
        if (srst || clear_all)
        begin
          wmap_q[gi] <= 1'b0;
          rmap_q[gi] <= 1'b0;
        end
        else if (set_valid && (set_row == AW'(gi)))
        begin
          wmap_q[gi] <= set_wprot;
          rmap_q[gi] <= set_rprot;
        end
      end
    end
  endgenerate

  // lookup is combinational; the parent registers the answer
  assign row_wprot = wmap_q[chk_row];
  assign row_rprot = rmap_q[chk_row];

endmodule // fpm_row_guard

// ---- fpm_ctrl.sv ----
// fpm_ctrl: chip-wide flash protection mode, debug gating, external erase
// gating and per-row access checks
// assumes: nonvolatile mode word held at nv_mode through the load cycles after srst falls,
// erase engine reports full-erase completion as a one-cycle pulse
`timescale 1ns/10ps
module fpm_ctrl #(
  parameter int unsigned ROWS = fpm_pkg::FPM_ROWS_DEF,
  parameter int unsigned AW   = fpm_pkg::FPM_ROW_AW_DEF
) (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic [1:0]          nv_mode,
  input  wire logic                req_valid,
  input  wire logic [1:0]          req_code,
  input  wire logic                full_erase_done,
  input  wire logic                dbg_mem_req,
  input  wire logic                dbg_ctl_req,
  input  wire logic                ext_erase_req,
  input  wire fpm_pkg::fpm_acc_type acc,
  input  wire logic                row_set_valid,
  input  wire logic [AW-1:0]       row_set_idx,
  input  wire logic                row_set_wprot,
  input  wire logic                row_set_rprot,
  output logic [2:0]               mode,
  output logic                     nv_write,
  output logic [1:0]               nv_wdata,
  output logic                     req_accept,
  output logic                     req_reject,
  output logic                     dbg_mem_grant,
  output logic                     dbg_ctl_grant,
  output logic                     dbg_deny,
  output logic                     ext_erase_start,
  output logic                     ext_erase_deny,
  output fpm_pkg::fpm_ans_type      acc_ans,
  output logic                     ready
);

  fpm_pkg::fpm_mode_type mode_q;
  fpm_pkg::fpm_mode_type mode_d;
  logic [1:0]            load_cnt_q;
  logic                  ready_q;
  logic                  erased_q;
  logic                  accept_d;
  logic                  reject_d;
  logic                  row_wprot;
  logic                  row_rprot;
  logic                  clear_rows;

  // ********************************************************************
  // reload from nonvolatile storage
  // ********************************************************************
  // nv_mode is caught by a clocked process after release, never by reset
  // itself; ready stays low so no debug grant can precede the load
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      load_cnt_q <= 2'h0;
      ready_q    <= fpm_pkg::FPM_RST_BOOTED;
    end
    else if (!ready_q)
    begin
      load_cnt_q <= load_cnt_q + 2'h1;
      if (load_cnt_q == 2'(fpm_pkg::FPM_LOAD_CYCLES - 1))
        ready_q <= 1'b1;
    end
  end

  // ********************************************************************
  // mode transitions
  // ********************************************************************
  // only open->protected, open->locked, protected->open after erase
  always_comb
  begin
    mode_d   = mode_q;
    accept_d = 1'b0;
    if (ready_q && req_valid)
    begin
      case (mode_q)
        fpm_pkg::FPM_MODE_OPEN:
        begin
          if (req_code == fpm_pkg::FPM_REQ_TO_PROTECTED)
            mode_d = fpm_pkg::FPM_MODE_PROTECTED;
          else if (req_code == fpm_pkg::FPM_REQ_TO_LOCKED)
            mode_d = fpm_pkg::FPM_MODE_LOCKED;
        end
        fpm_pkg::FPM_MODE_PROTECTED:
        begin
          if (req_code == fpm_pkg::FPM_REQ_TO_OPEN && erased_q)
            mode_d = fpm_pkg::FPM_MODE_OPEN;
        end
        default:
          mode_d = mode_q;
      endcase
      // every permitted change moves the mode, so a move means accepted
      accept_d = (mode_d != mode_q);
    end
    reject_d = ready_q && req_valid && !accept_d;
  end

  // mode register: loaded from storage during boot, then steered
  always_ff @(posedge clock)
  begin
    if (srst)
      mode_q <= fpm_pkg::FPM_MODE_OPEN;
    else if (!ready_q)
    begin
      if (nv_mode == fpm_pkg::FPM_NV_LOCKED)
        mode_q <= fpm_pkg::FPM_MODE_LOCKED;
      else if (nv_mode == fpm_pkg::FPM_NV_PROTECTED)
        mode_q <= fpm_pkg::FPM_MODE_PROTECTED;
      else
        mode_q <= fpm_pkg::FPM_MODE_OPEN;
    end
    else
      mode_q <= mode_d;
  end

  // ********************************************************************
  // full-erase tracking
  // ********************************************************************
  // set wins over the clear; cleared on leaving protected or on re-entry
  always_ff @(posedge clock)
  begin
    if (srst)
      erased_q <= 1'b0;
    else if (full_erase_done && mode_q == fpm_pkg::FPM_MODE_PROTECTED)
      erased_q <= 1'b1;
    else if (accept_d)
      erased_q <= 1'b0;
  end

  // ********************************************************************
  // nonvolatile write-back and request answers
  // ********************************************************************
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      nv_write   <= 1'b0;
      nv_wdata   <= fpm_pkg::FPM_RST_NV;
      req_accept <= 1'b0;
      req_reject <= 1'b0;
      mode       <= fpm_pkg::FPM_MODE_OPEN;
      ready      <= 1'b0;
    end
    else
    begin
      nv_write   <= accept_d;
      req_accept <= accept_d;
      req_reject <= reject_d;
      mode       <= mode_q;   // status copies lag the state by one cycle
      ready      <= ready_q;
      if (mode_d == fpm_pkg::FPM_MODE_LOCKED)
        nv_wdata <= fpm_pkg::FPM_NV_LOCKED;
      else if (mode_d == fpm_pkg::FPM_MODE_PROTECTED)
        nv_wdata <= fpm_pkg::FPM_NV_PROTECTED;
      else
        nv_wdata <= fpm_pkg::FPM_NV_OPEN;
    end
  end

  // ********************************************************************
  // debug gating
  // ********************************************************************
  // protected blocks memory accesses only; locked blocks control too
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dbg_mem_grant <= 1'b0;
      dbg_ctl_grant <= 1'b0;
      dbg_deny      <= 1'b0;
    end
    else
    begin
      dbg_mem_grant <= ready_q && dbg_mem_req
                       && mode_q == fpm_pkg::FPM_MODE_OPEN;
      dbg_ctl_grant <= ready_q && dbg_ctl_req
                       && mode_q != fpm_pkg::FPM_MODE_LOCKED;
      dbg_deny      <= (dbg_mem_req && (!ready_q || mode_q != fpm_pkg::FPM_MODE_OPEN))
                       || (dbg_ctl_req && (!ready_q
                       || mode_q == fpm_pkg::FPM_MODE_LOCKED));
    end
  end

  // ********************************************************************
  // external erase gating
  // ********************************************************************
  // no partial erase can start while locked; refused before boot too
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ext_erase_start <= 1'b0;
      ext_erase_deny  <= 1'b0;
    end
    else
    begin
      ext_erase_start <= ext_erase_req && ready_q
                         && mode_q != fpm_pkg::FPM_MODE_LOCKED;
      ext_erase_deny  <= ext_erase_req
                         && (!ready_q || mode_q == fpm_pkg::FPM_MODE_LOCKED);
    end
  end

  // ********************************************************************
  // row protection and internal access
  // ********************************************************************
  assign clear_rows = full_erase_done;

  fpm_row_guard #(
    .ROWS (ROWS),
    .AW   (AW)
  ) u_rows (
    .clock     (clock),
    .srst      (srst),
    .set_valid (row_set_valid),
    .set_row   (row_set_idx),
    .set_wprot (row_set_wprot),
    .set_rprot (row_set_rprot),
    .clear_all (clear_rows),
    .chk_row   (acc.row[AW-1:0]),
    .row_wprot (row_wprot),
    .row_rprot (row_rprot)
  );

  // internal system-call accesses bypass the row checks
  always_ff @(posedge clock)
  begin
    if (srst || !acc.valid)
      acc_ans <= '0;
    else if (acc.internal)
      acc_ans <= '{grant: 1'b1, deny: 1'b0};
    else if ((acc.wr && row_wprot) || (acc.rd && row_rprot))
      acc_ans <= '{grant: 1'b0, deny: 1'b1};
    else
      acc_ans <= '{grant: 1'b1, deny: 1'b0};
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  property p_locked_stays;
    @(posedge clock) disable iff (srst)
      (ready_q && mode_q == fpm_pkg::FPM_MODE_LOCKED) |=> mode_q == fpm_pkg::FPM_MODE_LOCKED;
  endproperty
  a_locked_stays: assert property (p_locked_stays) else $error("left locked");

  property p_prot_dbg;
    @(posedge clock) disable iff (srst)
      (mode_q != fpm_pkg::FPM_MODE_OPEN) |=> !dbg_mem_grant;
  endproperty
  a_prot_dbg: assert property (p_prot_dbg) else $error("debug mem granted");

  property p_lock_ctl;
    @(posedge clock) disable iff (srst)
      (dbg_ctl_req && mode_q == fpm_pkg::FPM_MODE_LOCKED) |=> dbg_deny && !dbg_ctl_grant;
  endproperty
  a_lock_ctl: assert property (p_lock_ctl) else $error("locked debug not denied");

  property p_lock_erase;
    @(posedge clock) disable iff (srst)
      (ext_erase_req && mode_q == fpm_pkg::FPM_MODE_LOCKED) |=> ext_erase_deny && !ext_erase_start;
  endproperty
  a_lock_erase: assert property (p_lock_erase) else $error("locked erase started");

  property p_open_needs_erase;
    @(posedge clock) disable iff (srst)
      ($past(mode_q) == fpm_pkg::FPM_MODE_PROTECTED && mode_q == fpm_pkg::FPM_MODE_OPEN
       && $past(ready_q)) |-> $past(erased_q);
  endproperty
  a_open_needs_erase: assert property (p_open_needs_erase) else $error("open w/o erase");

  property p_to_prot;
    @(posedge clock) disable iff (srst)
      (ready_q && req_valid && req_code == fpm_pkg::FPM_REQ_TO_PROTECTED
       && mode_q == fpm_pkg::FPM_MODE_OPEN)
      |=> mode_q == fpm_pkg::FPM_MODE_PROTECTED ##0 req_accept;
  endproperty
  a_to_prot: assert property (p_to_prot) else $error("open->protected lost");

  property p_to_lock;
    @(posedge clock) disable iff (srst)
      (ready_q && req_valid && req_code == fpm_pkg::FPM_REQ_TO_LOCKED
       && mode_q == fpm_pkg::FPM_MODE_OPEN)
      |=> mode_q == fpm_pkg::FPM_MODE_LOCKED ##1 mode == 3'h4;
  endproperty
  a_to_lock: assert property (p_to_lock) else $error("open->locked lost");

  property p_illegal_ignored;
    @(posedge clock) disable iff (srst)
      (ready_q && req_valid && mode_q == fpm_pkg::FPM_MODE_PROTECTED
       && req_code == fpm_pkg::FPM_REQ_TO_LOCKED) |=> $stable(mode_q) && req_reject;
  endproperty
  a_illegal_ignored: assert property (p_illegal_ignored) else $error("bad change taken");

  property p_internal;
    @(posedge clock) disable iff (srst)
      (acc.valid && acc.internal) |=> acc_ans.grant && !acc_ans.deny;
  endproperty
  a_internal: assert property (p_internal) else $error("internal access denied");

  property p_row_w;
    @(posedge clock) disable iff (srst)
      (acc.valid && !acc.internal && acc.wr && row_wprot) |=> acc_ans.deny;
  endproperty
  a_row_w: assert property (p_row_w) else $error("protected row written");

  property p_boot_nodbg;
    @(posedge clock) disable iff (srst)
      !ready_q |=> !dbg_mem_grant && !dbg_ctl_grant;
  endproperty
  a_boot_nodbg: assert property (p_boot_nodbg) else $error("debug before load");

  property p_reset_open;
    @(posedge clock) $fell(srst) |-> mode_q == fpm_pkg::FPM_MODE_OPEN;
  endproperty
  a_reset_open: assert property (p_reset_open) else $error("reset not open");

endmodule // fpm_ctrl

// ---- fpm_dbg_host.sv ----
// fpm_dbg_host: behavioural debug host facing the protection gate
// assumes: the bench calls its tasks just after a falling clock edge
`timescale 1ns/10ps
module fpm_dbg_host (
  output logic dbg_mem_req,
  output logic dbg_ctl_req,
  output logic ext_erase_req
);
  // ********************
  // host strobes
  // ********************
  // idle host: no strobe up until the bench asks
  initial
  begin
    dbg_mem_req   = 1'h0;
    dbg_ctl_req   = 1'h0;
    ext_erase_req = 1'h0;
  end

  // raise any mix of debug and erase strobes in one cycle
  task automatic drive(input logic mem, input logic ctl, input logic ext);
    dbg_mem_req   = mem;
    dbg_ctl_req   = ctl;
    ext_erase_req = ext;
  endtask

  // strobes are plain lines with no keeper, so idle means low
  task automatic idle();
    drive(1'h0, 1'h0, 1'h0);
  endtask
endmodule // fpm_dbg_host

// ---- flash_protection_mode_control_tb.sv ----
// flash_protection_mode_control_tb: self-checking bench for fpm_ctrl
// assumes: fpm_pkg and fpm_dbg_host are compiled first
`timescale 1ns/10ps
module flash_protection_mode_control_tb;
  logic                 clock = 1'h0;
  logic                 srst;
  logic [1:0]           nv_mode;
  logic                 req_valid;
  logic [1:0]           req_code;
  logic                 full_erase_done;
  logic                 dbg_mem_req, dbg_ctl_req, ext_erase_req;
  fpm_pkg::fpm_acc_type acc;
  logic                 row_set_valid, row_set_wprot, row_set_rprot;
  logic [7:0]           row_set_idx;
  logic [2:0]           mode;
  logic                 nv_write, req_accept, req_reject, ready;
  logic [1:0]           nv_wdata;
  logic                 dbg_mem_grant, dbg_ctl_grant, dbg_deny;
  logic                 ext_erase_start, ext_erase_deny;
  fpm_pkg::fpm_ans_type acc_ans;
  int                   n_errors = 0;
  int                   n_compared = 0;
  int                   m;       // model mode: 0 open, 1 protected, 2 locked
  logic                 erased;
  logic [255:0]         wp;
  logic [255:0]         rp;
  logic [7:0]           row_a;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  // ********************
  // design and host
  // ********************
  fpm_ctrl #(.ROWS(256), .AW(8)) dut (
    .clock, .srst, .nv_mode, .req_valid, .req_code, .full_erase_done,
    .dbg_mem_req, .dbg_ctl_req, .ext_erase_req, .acc, .row_set_valid,
    .row_set_idx, .row_set_wprot, .row_set_rprot, .mode, .nv_write, .nv_wdata,
    .req_accept, .req_reject, .dbg_mem_grant, .dbg_ctl_grant, .dbg_deny,
    .ext_erase_start, .ext_erase_deny, .acc_ans, .ready
  );

  fpm_dbg_host host (.dbg_mem_req, .dbg_ctl_req, .ext_erase_req);

  // ********************
  // reporting
  // ********************
  task automatic finish_test();
    $display("mismatches %0d of %0d compares", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // answer strobes packed as accept,reject,nvw,memg,ctlg,deny,ers,erd,grant,deny
  task automatic cmp_flags(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic cmp_mode(input logic [2:0] got, input logic [2:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t mode got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // ********************
  // operations with model
  // ********************
  // answers stand right after the taking edge; mode output lags one cycle more
  task automatic settle(input logic [9:0] exp, input logic [1:0] wd);
    @(negedge clock);
    cmp_flags({req_accept, req_reject, nv_write, dbg_mem_grant, dbg_ctl_grant,
               dbg_deny, ext_erase_start, ext_erase_deny, acc_ans}, exp);
    if (exp[7])
      cmp_flags({8'h00, nv_wdata}, {8'h00, wd});
    req_valid = 1'h0;
    full_erase_done = 1'h0;
    acc = '0;
    row_set_valid = 1'h0;
    host.idle();
    @(negedge clock);
    cmp_mode(mode, 3'h1 << m);
  endtask

  // only open->protected, open->locked and erased protected->open pass
  task automatic mode_req(input logic [1:0] code);
    int n;
    n = -1;
    if (m == 0 && (code == 2'h1 || code == 2'h2))
      n = code;
    if (m == 1 && code == 2'h0 && erased)
      n = 0;
    req_valid = 1'h1;
    req_code = code;
    if (n >= 0)
    begin
      m = n;
      erased = 1'h0;
    end
    settle((n >= 0) ? 10'h280 : 10'h100, code);
  endtask

  task automatic dbg(input logic mem, input logic ctl, input logic ext);
    logic mg;
    logic cg;
    mg = mem && m == 0;
    cg = ctl && m != 2;
    host.drive(mem, ctl, ext);
    settle({3'h0, mg, cg, (mem && !mg) || (ctl && !cg), ext && m != 2,
            ext && m == 2, 2'h0}, 2'h0);
  endtask

  task automatic access(input logic rd, input logic wr, input logic er,
                        input logic [7:0] row, input logic intl);
    logic dn;
    dn = !intl && ((wr && wp[row]) || (rd && rp[row]));
    acc = '{valid: 1'h1, rd: rd, wr: wr, er: er, row: row, internal: intl};
    settle({8'h00, !dn, dn}, 2'h0);
  endtask

  task automatic mark(input logic [7:0] row, input logic w, input logic r);
    row_set_valid = 1'h1;
    row_set_idx = row;
    row_set_wprot = w;
    row_set_rprot = r;
    wp[row] = w;
    rp[row] = r;
    settle(10'h000, 2'h0);
  endtask

  // a full erase wipes row markings; it only arms the return from protected
  task automatic erase_done();
    full_erase_done = 1'h1;
    if (m == 1)
      erased = 1'h1;
    wp = '0;
    rp = '0;
    settle(10'h000, 2'h0);
  endtask

  // debug held up through the load window must not be granted early
  task automatic do_reset(input logic [1:0] nv);
    int n;
    srst = 1'h1;
    nv_mode = nv;
    host.drive(1'h1, 1'h0, 1'h0);
    repeat (5) @(negedge clock);
    srst = 1'h0;
    n = 0;
    while (ready !== 1'h1 && n < 8)
    begin
      @(negedge clock);
      n++;
      if (n < 3)
        cmp_flags({4'h0, dbg_mem_grant, 5'h00}, 10'h000);
    end
    if (n >= 8)
    begin
      n_errors++;
      finish_test();
    end
    cmp_flags(10'(n), 10'h003);
    host.idle();
    m = (nv == 2'h3) ? 0 : int'(nv);
    erased = 1'h0;
    wp = '0;
    rp = '0;
    @(negedge clock);
    cmp_mode(mode, 3'h1 << m);
  endtask

  // ********************
  // main sequence
  // ********************
  initial
  begin
    req_valid = 1'h0;
    req_code = 2'h0;
    full_erase_done = 1'h0;
    acc = '0;
    row_set_valid = 1'h0;
    row_set_idx = 8'h00;
    row_set_wprot = 1'h0;
    row_set_rprot = 1'h0;
    void'($urandom(39));
    do_reset(2'h0);
    dbg(1'h1, 1'h1, 1'h1);
    row_a = 8'($urandom_range(255));
    mark(row_a, 1'h1, 1'h0);
    mark(row_a ^ 8'h5A, 1'h0, 1'h1);
    for (int i = 0; i < 32; i++)
      access(i[0], i[1], i[2], i[3] ? row_a : row_a ^ 8'h5A, i[4]);
    for (int i = 0; i < 8; i++)
      access(1'($urandom), 1'($urandom), 1'h0, 8'($urandom), 1'($urandom));
    mode_req(2'h1);
    dbg(1'h1, 1'h0, 1'h0);
    dbg(1'h0, 1'h1, 1'h1);
    access(1'h1, 1'h1, 1'h1, row_a, 1'h1);
    mode_req(2'h2);
    mode_req(2'h0);
    erase_done();
    access(1'h1, 1'h1, 1'h0, row_a, 1'h0);
    mode_req(2'h0);
    dbg(1'h1, 1'h0, 1'h0);
    mode_req(2'h2);
    dbg(1'h1, 1'h1, 1'h0);
    dbg(1'h0, 1'h0, 1'h1);
    access(1'h1, 1'h1, 1'h1, row_a, 1'h1);
    erase_done();
    for (int c = 0; c < 4; c++)
      mode_req(2'(c));
    do_reset(2'h1);
    dbg(1'h1, 1'h1, 1'h0);
    do_reset(2'h2);
    dbg(1'h1, 1'h1, 1'h1);
    do_reset(2'h3);
    mode_req(2'h3);
    finish_test();
  end
endmodule // flash_protection_mode_control_tb
